/* File: design/load_ctrl_defs.svh */
// Purpose: Constants for the load module remote-control block.
// Assumes: 100 MHz clock; 16-bit setpoint codes.
// Notes:   Register offsets, field positions, reset values, timing counts.
`ifndef LOAD_CTRL_DEFS_SVH
`define LOAD_CTRL_DEFS_SVH

// Register word offsets on the plain port.
`define A_WATT_LEVEL   5'h00
`define A_WATT_LIMIT   5'h01
`define A_WATT_FAULT   5'h02
`define A_OHM_LEVEL    5'h03
`define A_POTENTIAL_LEVEL_CMD_LEVEL   5'h04
`define A_HI_LIMIT     5'h05
`define A_HI_FAULT     5'h06
`define A_LO_LIMIT     5'h07
`define A_LO_FAULT     5'h08
`define A_MODE         5'h09
`define A_INPUT_ON     5'h0a
`define A_PROT_CLEAR   5'h0b
`define A_CHAN_EVENT   5'h0c
`define A_CHAN_COND    5'h0d
`define A_TRIGGER      5'h0e
`define A_OHM_PEAK     5'h10
`define A_OHM_DUR      5'h11
`define A_OHM_COUNT    5'h12
`define A_OHM_PERIOD   5'h13
`define A_POTENTIAL_LEVEL_CMD_PEAK    5'h14
`define A_POTENTIAL_LEVEL_CMD_DUR     5'h15
`define A_POTENTIAL_LEVEL_CMD_COUNT   5'h16
`define A_POTENTIAL_LEVEL_CMD_PERIOD  5'h17

// Channel event bit positions.
`define EV_VF 0
`define EV_OC 1
`define EV_OP 3
`define EV_OT 4
`define EV_OV 12
`define EV_PS 13

// Transient timing: durations are in units of 0.1 ms.
`define TICK_NS        100000
`define CLK_NS         10
`define TICK_CYC       (`TICK_NS / `CLK_NS)
`define MIN_DUR_US     500
`define MIN_DUR_TICKS  16'h0005
`define MAX_COUNT      16'hfde8
`define DEF_COUNT      16'h0001
`define RST_LEVEL      16'h0000
`endif

/* File: design/load_ctrl_pkg.sv */
// Purpose: Types for the load module remote-control block.
// Assumes: Constants come from load_ctrl_defs.svh.
// Notes:   Mode encoding is one-hot.
package load_ctrl_pkg;
  typedef enum logic [6:0] {
    MODE_OFF   = 7'h01,
    MODE_CURR  = 7'h02,
    MODE_WATT  = 7'h04,
    MODE_POTENTIAL_LEVEL_CMD  = 7'h08,
    MODE_OHM   = 7'h10,
    MODE_COND  = 7'h20,
    MODE_SHORT = 7'h40
  } op_mode_e;

  typedef enum logic [2:0] {
    PT_IDLE = 3'h1,
    PT_HIGH = 3'h2,
    PT_LOW  = 3'h4
  } pulse_state_e;

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] dur;
    logic [15:0] count;
    logic [15:0] period;
  } pulse_cfg_s;

  typedef struct packed {
    logic [15:0] watts;
    logic [15:0] volts;
    logic        over_current;
    logic        over_temp;
  } meas_s;
endpackage : load_ctrl_pkg

/* File: design/load_setpoint_protection_transient_ctrl.sv */
// Purpose: Remote-control logic of one load module: setpoints, limits,
//          protection flags, transient pulse trains and channel events.
// Assumes: Plain register port; read data valid the cycle after the strobe.
// Notes:   Non-volatile values enter on nv_* ports and are taken on the first clock after reset releases.
`timescale 1ns/100ps
`include "load_ctrl_defs.svh"

module load_setpoint_protection_transient_ctrl
  import load_ctrl_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire meas_s       meas_i,
  input  wire logic [15:0] nv_ohm_i,
  input  wire logic [15:0] nv_potential_level_cmd_i,
  input  wire logic [15:0] nv_hi_i,
  input  wire logic [15:0] nv_lo_i,
  output logic             input_on_o,
  output op_mode_e         mode_o,
  output logic      [15:0] drive_level_o,
  output logic             pulse_active_o
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0] watt_lvl_r, watt_lvl_nxt, watt_lim_r, watt_lim_nxt;
  logic [15:0] ohm_lvl_r, ohm_lvl_nxt, potential_level_cmd_lvl_r, potential_level_cmd_lvl_nxt;
  logic [15:0] hi_lim_r, hi_lim_nxt, lo_lim_r, lo_lim_nxt;
  logic        watt_flt_r, watt_flt_nxt, hi_flt_r, hi_flt_nxt;
  logic        lo_flt_r, lo_flt_nxt, on_r, on_nxt, init_r, init_nxt;
  logic [15:0] event_r, event_nxt, rdata_r, rdata_nxt;
  op_mode_e    mode_r, mode_nxt;
  pulse_cfg_s  ohm_cfg_r, ohm_cfg_nxt, potential_level_cmd_cfg_r, potential_level_cmd_cfg_nxt;
  logic        trig;
  logic        watt_hit, hi_hit, lo_hit;
  logic        clr_all;
  logic [15:0] cond;

  function automatic logic [15:0] clamp_dur(input logic [15:0] d);
    clamp_dur = (d < `MIN_DUR_TICKS) ? `MIN_DUR_TICKS : d;
  endfunction : clamp_dur

  function automatic logic [15:0] clamp_cnt(input logic [15:0] c);
    clamp_cnt = (c == 16'h0000) ? `DEF_COUNT : ((c > `MAX_COUNT) ? `MAX_COUNT : c);
  endfunction : clamp_cnt

  function automatic logic [15:0] clamp_per(input logic [15:0] p,
                                            input logic [15:0] d);
    logic [16:0] least;
    least = {1'b0, d} + {1'b0, `MIN_DUR_TICKS};
    // nonzero period at least duration plus minimum; zero stays zero.
    if (p == 16'h0000)
      clamp_per = 16'h0000;
    else if ({1'b0, p} < least)
      clamp_per = (least[16]) ? 16'hffff : least[15:0];
    else
      clamp_per = p;
  endfunction : clamp_per

  // ****************************************************************
  // Protection detection
  // ****************************************************************
  always_comb
  begin
    watt_hit = on_r && (meas_i.watts > watt_lim_r);
    hi_hit   = meas_i.volts > hi_lim_r;
    lo_hit   = meas_i.volts < lo_lim_r;
    cond = 16'h0000;
    cond[`EV_OC] = meas_i.over_current;
    cond[`EV_OP] = watt_hit;
    cond[`EV_OT] = meas_i.over_temp;
    cond[`EV_OV] = hi_hit;
    cond[`EV_VF] = lo_hit;
    cond[`EV_PS] = watt_hit | hi_hit | lo_hit;
  end

  assign clr_all = wr_i && (addr_i == `A_PROT_CLEAR);
  assign trig    = wr_i && (addr_i == `A_TRIGGER);

  // ****************************************************************
  // Register writes, flags and reads
  // ****************************************************************
  always_comb
  begin
    watt_lvl_nxt = watt_lvl_r;
    watt_lim_nxt = watt_lim_r;
    ohm_lvl_nxt  = ohm_lvl_r;
    potential_level_cmd_lvl_nxt = potential_level_cmd_lvl_r;
    hi_lim_nxt   = hi_lim_r;
    lo_lim_nxt   = lo_lim_r;
    mode_nxt     = mode_r;
    on_nxt       = on_r;
    ohm_cfg_nxt  = ohm_cfg_r;
    potential_level_cmd_cfg_nxt = potential_level_cmd_cfg_r;
    watt_flt_nxt = watt_flt_r;
    hi_flt_nxt   = hi_flt_r;
    lo_flt_nxt   = lo_flt_r;
    event_nxt    = event_r;
    init_nxt     = 1'b0;
    rdata_nxt    = 16'h0000;
    if (init_r)
    begin
      ohm_lvl_nxt  = nv_ohm_i;
      potential_level_cmd_lvl_nxt = nv_potential_level_cmd_i;
      hi_lim_nxt   = nv_hi_i;
      lo_lim_nxt   = nv_lo_i;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `A_WATT_LEVEL: watt_lvl_nxt = wdata_i;
        `A_WATT_LIMIT: watt_lim_nxt = wdata_i;
        `A_OHM_LEVEL:  ohm_lvl_nxt  = wdata_i;
        `A_POTENTIAL_LEVEL_CMD_LEVEL: potential_level_cmd_lvl_nxt = wdata_i;
        `A_HI_LIMIT:   hi_lim_nxt   = wdata_i;
        `A_LO_LIMIT:   lo_lim_nxt   = wdata_i;
        `A_WATT_FAULT: if (wdata_i == 16'h0000) watt_flt_nxt = 1'b0;
        `A_HI_FAULT:   if (wdata_i == 16'h0000) hi_flt_nxt = 1'b0;
        `A_LO_FAULT:   if (wdata_i == 16'h0000) lo_flt_nxt = 1'b0;
        `A_CHAN_COND:  if (wdata_i == 16'h0000) event_nxt = 16'h0000;
        `A_MODE:
        begin
          if (wdata_i[6:0] != mode_r &&
              $onehot(wdata_i[6:0]))
          begin
            mode_nxt = op_mode_e'(wdata_i[6:0]);
            on_nxt   = 1'b0;
          end
        end
        `A_INPUT_ON:   on_nxt = wdata_i[0];
        `A_OHM_PEAK:   ohm_cfg_nxt = '{wdata_i, `MIN_DUR_TICKS, `DEF_COUNT, 16'h0000};
        `A_OHM_DUR:    ohm_cfg_nxt.dur = clamp_dur(wdata_i);
        `A_OHM_COUNT:  ohm_cfg_nxt.count = clamp_cnt(wdata_i);
        `A_OHM_PERIOD: ohm_cfg_nxt.period = clamp_per(wdata_i, ohm_cfg_r.dur);
        `A_POTENTIAL_LEVEL_CMD_PEAK:  potential_level_cmd_cfg_nxt = '{wdata_i, `MIN_DUR_TICKS, `DEF_COUNT, 16'h0000};
        `A_POTENTIAL_LEVEL_CMD_DUR:   potential_level_cmd_cfg_nxt.dur = clamp_dur(wdata_i);
        `A_POTENTIAL_LEVEL_CMD_COUNT: potential_level_cmd_cfg_nxt.count = clamp_cnt(wdata_i);
        `A_POTENTIAL_LEVEL_CMD_PERIOD: potential_level_cmd_cfg_nxt.period = clamp_per(wdata_i, potential_level_cmd_cfg_r.dur);
        default: ;
      endcase
    end
    if (clr_all)
    begin
      watt_flt_nxt = 1'b0;
      hi_flt_nxt   = 1'b0;
      lo_flt_nxt   = 1'b0;
    end
    // Events set after clears so a simultaneous event survives.
    if (watt_hit)
    begin
      watt_flt_nxt = 1'b1;
      on_nxt       = 1'b0;
    end
    if (hi_hit)
      hi_flt_nxt = 1'b1;
    if (lo_hit)
      lo_flt_nxt = 1'b1;
    event_nxt = event_nxt | cond;
    if (rd_i)
    begin
      case (addr_i)
        `A_WATT_LEVEL:  rdata_nxt = watt_lvl_r;
        `A_WATT_LIMIT:  rdata_nxt = watt_lim_r;
        `A_OHM_LEVEL:   rdata_nxt = ohm_lvl_r;
        `A_POTENTIAL_LEVEL_CMD_LEVEL:  rdata_nxt = potential_level_cmd_lvl_r;
        `A_HI_LIMIT:    rdata_nxt = hi_lim_r;
        `A_LO_LIMIT:    rdata_nxt = lo_lim_r;
        `A_WATT_FAULT:  rdata_nxt = {15'h0000, watt_flt_r};
        `A_HI_FAULT:    rdata_nxt = {15'h0000, hi_flt_r};
        `A_LO_FAULT:    rdata_nxt = {15'h0000, lo_flt_r};
        `A_MODE:        rdata_nxt = {9'h000, mode_r};
        `A_INPUT_ON:    rdata_nxt = {15'h0000, on_r};
        `A_CHAN_EVENT:  rdata_nxt = event_r;
        `A_CHAN_COND:   rdata_nxt = cond;
        `A_OHM_PEAK:    rdata_nxt = ohm_cfg_r.peak;
        `A_OHM_DUR:     rdata_nxt = ohm_cfg_r.dur;
        `A_OHM_COUNT:   rdata_nxt = ohm_cfg_r.count;
        `A_OHM_PERIOD:  rdata_nxt = ohm_cfg_r.period;
        `A_POTENTIAL_LEVEL_CMD_PEAK:   rdata_nxt = potential_level_cmd_cfg_r.peak;
        `A_POTENTIAL_LEVEL_CMD_DUR:    rdata_nxt = potential_level_cmd_cfg_r.dur;
        `A_POTENTIAL_LEVEL_CMD_COUNT:  rdata_nxt = potential_level_cmd_cfg_r.count;
        `A_POTENTIAL_LEVEL_CMD_PERIOD: rdata_nxt = potential_level_cmd_cfg_r.period;
        default:        rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      watt_lvl_r <= `RST_LEVEL;
      watt_lim_r <= 16'hffff;
      ohm_lvl_r  <= `RST_LEVEL;
      potential_level_cmd_lvl_r <= `RST_LEVEL;
      hi_lim_r   <= 16'hffff;
      lo_lim_r   <= `RST_LEVEL;
      mode_r     <= MODE_OFF;
      on_r       <= 1'b0;
      ohm_cfg_r  <= '{`RST_LEVEL, `MIN_DUR_TICKS, `DEF_COUNT, 16'h0000};
      potential_level_cmd_cfg_r <= '{`RST_LEVEL, `MIN_DUR_TICKS, `DEF_COUNT, 16'h0000};
      watt_flt_r <= 1'b0;
      hi_flt_r   <= 1'b0;
      lo_flt_r   <= 1'b0;
      event_r    <= 16'h0000;
      init_r     <= 1'b1;
      rdata_r    <= 16'h0000;
    end
    else
    begin
      watt_lvl_r <= watt_lvl_nxt;
      watt_lim_r <= watt_lim_nxt;
      ohm_lvl_r  <= ohm_lvl_nxt;
      potential_level_cmd_lvl_r <= potential_level_cmd_lvl_nxt;
      hi_lim_r   <= hi_lim_nxt;
      lo_lim_r   <= lo_lim_nxt;
      mode_r     <= mode_nxt;
      on_r       <= on_nxt;
      ohm_cfg_r  <= ohm_cfg_nxt;
      potential_level_cmd_cfg_r <= potential_level_cmd_cfg_nxt;
      watt_flt_r <= watt_flt_nxt;
      hi_flt_r   <= hi_flt_nxt;
      lo_flt_r   <= lo_flt_nxt;
      event_r    <= event_nxt;
      init_r     <= init_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Transient pulse train
  // ****************************************************************
  pulse_state_e ps_r, ps_nxt;
  logic [13:0]  pre_r, pre_nxt;
  logic [15:0]  tk_r, tk_nxt, rep_r, rep_nxt;
  logic         tick;
  pulse_cfg_s   act;

  always_comb
  begin
    act  = (mode_r == MODE_OHM) ? ohm_cfg_r : potential_level_cmd_cfg_r;
    tick = (pre_r == 14'(`TICK_CYC - 1));
    pre_nxt = (ps_r == PT_IDLE || tick) ? 14'h0000 : pre_r + 14'h0001;
    ps_nxt  = ps_r;
    tk_nxt  = tk_r;
    rep_nxt = rep_r;
    case (ps_r)
      PT_IDLE:
      begin
        // only the trigger starts a train.
        if (trig && on_nxt && (mode_r == MODE_OHM || mode_r == MODE_POTENTIAL_LEVEL_CMD))
        begin
          ps_nxt  = PT_HIGH;
          tk_nxt  = 16'h0000;
          rep_nxt = act.count;
        end
      end
      PT_HIGH:
      begin
        if (tick)
        begin
          tk_nxt = tk_r + 16'h0001;
          if (tk_nxt >= act.dur)
          begin
            rep_nxt = rep_r - 16'h0001;
            // back to base between and after pulses.
            if (rep_nxt == 16'h0000)
              ps_nxt = PT_IDLE;
            else
              ps_nxt = PT_LOW;
          end
        end
      end
      PT_LOW:
      begin
        if (tick)
        begin
          tk_nxt = tk_r + 16'h0001;
          if (tk_nxt >= ((act.period == 16'h0000) ? 16'(act.dur + `MIN_DUR_TICKS) : act.period))
          begin
            ps_nxt = PT_HIGH;
            tk_nxt = 16'h0000;
          end
        end
      end
      default: ps_nxt = PT_IDLE;
    endcase
    if (!on_r)
      ps_nxt = PT_IDLE;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      ps_r  <= PT_IDLE;
      pre_r <= 14'h0000;
      tk_r  <= 16'h0000;
      rep_r <= 16'h0000;
    end
    else
    begin
      ps_r  <= ps_nxt;
      pre_r <= pre_nxt;
      tk_r  <= tk_nxt;
      rep_r <= rep_nxt;
    end
  end

  // ****************************************************************
  // Load drive
  // ****************************************************************
  logic [15:0] drive_r, drive_nxt;

  always_comb
  begin
    case (mode_r)
      // wattage setpoint in wattage mode only.
      MODE_WATT: drive_nxt = watt_lvl_r;
      // ohmic setpoint in ohmic mode only.
      MODE_OHM:  drive_nxt = (ps_r == PT_HIGH) ? ohm_cfg_r.peak : ohm_lvl_r;
      // potential setpoint in potential mode only.
      MODE_POTENTIAL_LEVEL_CMD: drive_nxt = (ps_r == PT_HIGH) ? potential_level_cmd_cfg_r.peak : potential_level_cmd_lvl_r;
      default:   drive_nxt = 16'h0000;
    endcase
    if (!on_r)
      drive_nxt = 16'h0000;
  end

  always_ff @(posedge clock_i)
  begin
    drive_r <= (!rst_b_i) ? 16'h0000 : drive_nxt;
  end

  assign rdata_o        = rdata_r;
  assign input_on_o     = on_r;
  assign mode_o         = mode_r;
  assign drive_level_o  = drive_r;
  assign pulse_active_o = (ps_r == PT_HIGH);

endmodule : load_setpoint_protection_transient_ctrl

/* File: test/load_ctrl_props.sv */
// Purpose: Port-level checks of the load module control block.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Attached to the design by the bind at the foot.
`timescale 1ns/100ps
`include "load_ctrl_defs.svh"

module load_ctrl_props
  import load_ctrl_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic [4:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        input_on_o,
  input wire op_mode_e    mode_o,
  input wire logic [15:0] drive_level_o,
  input wire logic        pulse_active_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_rdata_idle;
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

  property p_unmapped;
    rd_i && (addr_i == 5'h0f || addr_i > 5'h17) |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_flag_bits;
    rd_i && (addr_i == `A_WATT_FAULT || addr_i == `A_HI_FAULT || addr_i == `A_LO_FAULT)
      |=> rdata_o[15:1] == 15'h0000;
  endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("fault flag wider than one bit");

  property p_event_nu;
    rd_i && addr_i == `A_CHAN_EVENT |=> rdata_o[15:14] == 2'b00 && rdata_o[11:5] == 7'h00
      && !rdata_o[2];
  endproperty
  a_event_nu: assert property (p_event_nu) else $error("unused event bit set");

  property p_mode_drop;
    wr_i && addr_i == `A_MODE && $onehot(wdata_i) && wdata_i[15:7] == 9'h000
      && wdata_i[6:0] != mode_o |=> !input_on_o;
  endproperty
  a_mode_drop: assert property (p_mode_drop) else $error("input kept on over mode change");

  property p_on_cause;
    $rose(input_on_o) |-> $past(wr_i && addr_i == `A_INPUT_ON && wdata_i[0]);
  endproperty
  a_on_cause: assert property (p_on_cause) else $error("input engaged without command");

  property p_onehot;
    $onehot(mode_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");

  property p_drive_off;
    !input_on_o |=> drive_level_o == 16'h0000;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive while input off");

  property p_drive_mode;
    !(mode_o inside {MODE_WATT, MODE_POTENTIAL_LEVEL_CMD, MODE_OHM}) |=> drive_level_o == 16'h0000;
  endproperty
  a_drive_mode: assert property (p_drive_mode) else $error("drive in foreign mode");

  property p_pulse_mode;
    $rose(pulse_active_o) |-> input_on_o && (mode_o == MODE_OHM || mode_o == MODE_POTENTIAL_LEVEL_CMD);
  endproperty
  a_pulse_mode: assert property (p_pulse_mode) else $error("pulse in wrong state");

  property p_pulse_abort;
    pulse_active_o && !input_on_o |=> !pulse_active_o;
  endproperty
  a_pulse_abort: assert property (p_pulse_abort) else $error("pulse kept with input off");
endmodule : load_ctrl_props

bind load_setpoint_protection_transient_ctrl load_ctrl_props u_props (
  .clock_i        (clock_i),
  .rst_b_i        (rst_b_i),
  .addr_i         (addr_i),
  .wdata_i        (wdata_i),
  .wr_i           (wr_i),
  .rd_i           (rd_i),
  .rdata_o        (rdata_o),
  .input_on_o     (input_on_o),
  .mode_o         (mode_o),
  .drive_level_o  (drive_level_o),
  .pulse_active_o (pulse_active_o)
);

/* File: test/host_bus_model.sv */
// Purpose: Host controller on the plain register port.
// Assumes: Read data stands only in the cycle after the strobe.
// Notes:   Idle data is inverted after a write, idle address after a read, so stale values never pass.
`timescale 1ns/100ps

module host_bus_model
(
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  output logic      [4:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial
  begin
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
    @(posedge clock_i);
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    @(posedge clock_i);
    #1;
  endtask : read_reg
endmodule : host_bus_model

/* File: test/load_setpoint_protection_transient_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the load module control block.
// Assumes: 100 MHz clock; host model drives the register port.
// Notes:   One full pulse of minimum length runs at the end.
`timescale 1ns/100ps
`include "load_ctrl_defs.svh"

module load_setpoint_protection_transient_ctrl_tb_top
  import load_ctrl_pkg::*;
;
  localparam logic [15:0] NV_OHM  = 16'h0123;
  localparam logic [15:0] NV_POTENTIAL_LEVEL_CMD = 16'h0456;
  localparam logic [15:0] NV_HI   = 16'h0800;
  localparam logic [15:0] NV_LO   = 16'h0100;

  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] drive;
  logic [15:0] v;
  logic        wr;
  logic        rd;
  logic        on;
  logic        pact;
  meas_s       meas;
  op_mode_e    mode;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  always #5 clock_i = ~clock_i;

  load_setpoint_protection_transient_ctrl u_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .meas_i(meas), .nv_ohm_i(NV_OHM), .nv_potential_level_cmd_i(NV_POTENTIAL_LEVEL_CMD),
    .nv_hi_i(NV_HI), .nv_lo_i(NV_LO), .input_on_o(on), .mode_o(mode),
    .drive_level_o(drive), .pulse_active_o(pact));

  host_bus_model u_host (
    .clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    u_host.read_reg(a, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic t_reset;
    rd_chk(`A_WATT_LEVEL, 16'h0000);
    rd_chk(`A_WATT_LIMIT, 16'hffff);
    rd_chk(`A_OHM_LEVEL, NV_OHM);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_LEVEL, NV_POTENTIAL_LEVEL_CMD);
    rd_chk(`A_HI_LIMIT, NV_HI);
    rd_chk(`A_LO_LIMIT, NV_LO);
    rd_chk(`A_MODE, 16'h0001);
    rd_chk(5'h1f, 16'h0000);
  endtask : t_reset

  task automatic t_modes;
    op_mode_e    mt[4] = '{MODE_OHM, MODE_POTENTIAL_LEVEL_CMD, MODE_WATT, MODE_CURR};
    logic [15:0] lt[4] = '{16'h0022, 16'h0033, 16'h0011, 16'h0000};
    u_host.write_reg(`A_WATT_LEVEL, 16'h0011);
    u_host.write_reg(`A_OHM_LEVEL, 16'h0022);
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_LEVEL, 16'h0033);
    rd_chk(`A_OHM_LEVEL, 16'h0022);
    for (int i = 0; i < 4; i++)
    begin
      u_host.write_reg(`A_MODE, {9'h000, mt[i]});
      chk({15'h0000, on}, 16'h0000);
      u_host.write_reg(`A_INPUT_ON, 16'h0001);
      cyc(1);
      chk(drive, lt[i]);
    end
  endtask : t_modes

  task automatic t_watt;
    u_host.write_reg(`A_WATT_LIMIT, 16'h0100);
    u_host.write_reg(`A_MODE, {9'h000, MODE_WATT});
    u_host.write_reg(`A_INPUT_ON, 16'h0001);
    meas.watts <= 16'h0200;
    cyc(3);
    chk({15'h0000, on}, 16'h0000);
    meas.watts <= 16'h0010;
    rd_chk(`A_WATT_FAULT, 16'h0001);
    rd_chk(`A_CHAN_EVENT, (16'h0001 << `EV_OP) | (16'h0001 << `EV_PS));
    u_host.write_reg(`A_WATT_FAULT, 16'h0000);
    rd_chk(`A_WATT_FAULT, 16'h0000);
    rd_chk(`A_CHAN_EVENT, (16'h0001 << `EV_OP) | (16'h0001 << `EV_PS));
    u_host.write_reg(`A_CHAN_COND, 16'h0000);
    rd_chk(`A_CHAN_EVENT, 16'h0000);
  endtask : t_watt

  task automatic t_potential_level_cmd;
    meas.volts <= 16'h0900;
    cyc(2);
    meas.volts <= 16'h0080;
    cyc(2);
    meas.volts <= 16'h0200;
    cyc(1);
    rd_chk(`A_HI_FAULT, 16'h0001);
    rd_chk(`A_LO_FAULT, 16'h0001);
    rd_chk(`A_CHAN_EVENT, 16'h3001);
    u_host.write_reg(`A_HI_FAULT, 16'h0000);
    u_host.write_reg(`A_LO_FAULT, 16'h0000);
    rd_chk(`A_HI_FAULT, 16'h0000);
    rd_chk(`A_LO_FAULT, 16'h0000);
    meas.volts <= 16'h0900;
    cyc(2);
    meas.volts <= 16'h0200;
    u_host.write_reg(`A_PROT_CLEAR, 16'h0000);
    rd_chk(`A_HI_FAULT, 16'h0000);
    u_host.write_reg(`A_CHAN_COND, 16'h0000);
  endtask : t_potential_level_cmd

  task automatic t_cfg;
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_PEAK, 16'h0300);
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_DUR, 16'h0002);
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_COUNT, 16'hffff);
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_PERIOD, 16'h0007);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_PEAK, 16'h0300);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_DUR, 16'h0005);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_COUNT, 16'hfde8);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_PERIOD, 16'h000a);
    u_host.write_reg(`A_POTENTIAL_LEVEL_CMD_COUNT, 16'h0000);
    rd_chk(`A_POTENTIAL_LEVEL_CMD_COUNT, 16'h0001);
    u_host.write_reg(`A_OHM_DUR, 16'h0009);
    u_host.write_reg(`A_OHM_PEAK, 16'h0055);
    rd_chk(`A_OHM_DUR, 16'h0005);
    rd_chk(`A_OHM_PEAK, 16'h0055);
  endtask : t_cfg

  task automatic t_pulse;
    u_host.write_reg(`A_MODE, {9'h000, MODE_POTENTIAL_LEVEL_CMD});
    u_host.write_reg(`A_INPUT_ON, 16'h0001);
    cyc(3);
    chk({15'h0000, pact}, 16'h0000);
    u_host.write_reg(`A_TRIGGER, 16'h0001);
    for (n = 0; pact !== 1'b1 && n < 20; n++)
      cyc(1);
    cyc(1);
    chk(drive, 16'h0300);
    cyc(1000);
    chk({15'h0000, pact}, 16'h0001);
    for (n = 0; pact !== 1'b0 && n < 60000; n++)
      cyc(1);
    chk(16'(n), 16'(5 * `TICK_CYC - 1002));
    cyc(3);
    chk({15'h0000, pact}, 16'h0000);
    chk(drive, 16'h0033);
    u_host.write_reg(`A_TRIGGER, 16'h0001);
    cyc(5);
    chk({15'h0000, pact}, 16'h0001);
    u_host.write_reg(`A_INPUT_ON, 16'h0000);
    chk({15'h0000, pact}, 16'h0000);
    chk(drive, 16'h0000);
    u_host.write_reg(`A_TRIGGER, 16'h0001);
    chk({15'h0000, pact}, 16'h0000);
  endtask : t_pulse

  initial
  begin
    meas = '{watts: 16'h0000, volts: 16'h0200, over_current: 1'b0, over_temp: 1'b0};
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    cyc(2);
    t_reset();
    t_modes();
    t_watt();
    t_potential_level_cmd();
    t_cfg();
    t_pulse();
    test_done();
  end

  initial
  begin
    repeat (90000) @(posedge clock_i);
    mismatches++;
    test_done();
  end
endmodule : load_setpoint_protection_transient_ctrl_tb_top
